// [src/branch_and_cond_logic_unit.sv]
// branch and condition-logic unit: targets, conditions, condition register
// assumes decoded operands arrive synchronously, one issue per valid cycle;
// registers are reached by an AHB-Lite master with single word transfers
//
// The implementer's own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module branch_and_cond_logic_unit (
   // clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        rst_in,
   // AHB-Lite slave
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic [31:0]      hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   // decoded instruction from decode
   input  wire logic        issue_valid_in,
   input  wire logic [3:0]  op_in,
   input  wire logic        absolute_in,
   input  wire logic        link_in,
   input  wire logic [4:0]  branch_option_field_in,
   input  wire logic [4:0]  cond_selector_in,
   input  wire logic [4:0]  src_bit_first_in,
   input  wire logic [4:0]  src_bit_second_in,
   input  wire logic [4:0]  dest_cond_bit_in,
   input  wire logic [2:0]  src_field_in,
   input  wire logic [2:0]  dest_field_in,
   input  wire logic [63:0] instr_addr_in,
   input  wire logic [63:0] disp_in,
   // result toward fetch and exception logic
   output logic             result_valid_out,
   output logic [63:0]      fetch_addr_out,
   output logic             taken_out,
   output logic             illegal_out
);

   // architectural state
   logic [31:0] condition_reg_q;
   logic [63:0] return_addr_reg_q;
   logic [63:0] loop_count_reg_q;
   logic [31:0] ctrl_q;
   // bus data-phase state
   logic        wr_pend_q;
   logic        rd_pend_q;
   logic [7:0]  bus_addr_q;
   // decode results
   logic        is_branch;
   logic        is_crlog;
   logic        illegal_d;
   logic        sel_bit;
   logic        eval_taken;
   logic        eval_dec;
   logic [63:0] count_next;
   logic [63:0] target_d;
   logic [63:0] seq_addr;
   logic        taken_d;
   logic        mode32;
   logic        do_branch;
   logic        do_crlog;
   logic [31:0] cond_next;
   logic        logic_res;

   assign mode32 = ctrl_q[branch_logic_pkg::CTRL_MODE32_BIT];

   // condition bit 0 is the most significant bit of the register
   function automatic logic cond_bit(input logic [31:0] cr,
                                     input logic [4:0]  idx);
      cond_bit = cr[5'd31 - idx];
   endfunction : cond_bit

   // register-indirect target: word aligned, upper half cut in 32-bit mode
   function automatic logic [63:0] indirect_target(input logic [63:0] src,
                                                   input logic        m32);
      logic [63:0] t;
      t = src & branch_logic_pkg::ALIGN_MASK;
      indirect_target = m32 ? (t & branch_logic_pkg::LOW_HALF) : t;
   endfunction : indirect_target

   // bit operation of the condition-logic group
   function automatic logic cond_logic(input logic [3:0] op,
                                       input logic       a,
                                       input logic       b);
      case (op)
         branch_logic_pkg::OP_CR_AND:  cond_logic = a & b;
         branch_logic_pkg::OP_CR_OR:   cond_logic = a | b;
         branch_logic_pkg::OP_CR_XOR:  cond_logic = a ^ b;
         branch_logic_pkg::OP_CR_NAND: cond_logic = ~(a & b);
         branch_logic_pkg::OP_CR_NOR:  cond_logic = ~(a | b);
         branch_logic_pkg::OP_CR_EQV:  cond_logic = ~(a ^ b);
         branch_logic_pkg::OP_CR_ANDC: cond_logic = a & ~b;
         branch_logic_pkg::OP_CR_ORC:  cond_logic = a | ~b;
         // field move and the branch codes never use this result
         default:                      cond_logic = 1'b0;
      endcase
   endfunction : cond_logic

   // condition evaluation for the three conditional families
   branch_cond_eval #(
      .CNT_W          (64)
   ) u_eval (
      .sys_clk_in     (sys_clk_in),
      .rst_in         (rst_in),
      .option_in      (branch_option_field_in),
      .cond_bit_in    (sel_bit),
      .count_in       (loop_count_reg_q),
      .mode32_in      (mode32),
      .uncond_in      (op_in == branch_logic_pkg::OP_BR_UNCOND),
      .taken_out      (eval_taken),
      .dec_out        (eval_dec),
      .count_next_out (count_next)
   );

   // decode, legality and target selection
   always_comb
   begin
      is_branch = (op_in >= branch_logic_pkg::OP_BR_UNCOND) &&
                  (op_in <= branch_logic_pkg::OP_BR_CNT);
      is_crlog  = (op_in >= branch_logic_pkg::OP_CR_AND) ||
                  (op_in == branch_logic_pkg::OP_CR_ORC);
      sel_bit   = cond_bit(condition_reg_q, cond_selector_in);
      illegal_d = ((op_in == branch_logic_pkg::OP_BR_CNT) &&
                   !branch_option_field_in[branch_logic_pkg::OPT_NO_DEC])
                  || (is_crlog && link_in)
                  || (!is_branch && !is_crlog &&
                      (op_in != branch_logic_pkg::OP_IDLE));
      seq_addr  = instr_addr_in + branch_logic_pkg::INSTR_BYTES;
      case (op_in)
         branch_logic_pkg::OP_BR_RET:
            target_d = indirect_target(return_addr_reg_q, mode32);
         branch_logic_pkg::OP_BR_CNT:
            target_d = indirect_target(loop_count_reg_q, mode32);
         default:
            target_d = absolute_in ? disp_in
                                   : instr_addr_in + disp_in;
      endcase
      do_branch = issue_valid_in && is_branch && !illegal_d;
      do_crlog  = issue_valid_in && is_crlog && !illegal_d;
      taken_d   = do_branch && eval_taken;
   end

   // new condition register value for logic ops and field moves
   always_comb
   begin
      cond_next = condition_reg_q;
      logic_res = cond_logic(op_in,
                             cond_bit(condition_reg_q, src_bit_first_in),
                             cond_bit(condition_reg_q, src_bit_second_in));
      if (op_in == branch_logic_pkg::OP_CR_MOVE)
      begin
         cond_next[5'(28) - 5'({dest_field_in, 2'b00}) +: 4] =
            condition_reg_q[5'(28) - 5'({src_field_in, 2'b00}) +: 4];
      end
      else
      begin
         cond_next[5'd31 - dest_cond_bit_in] = logic_res;
      end
   end

   // bus address phase captured; slave never stalls
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         wr_pend_q  <= 1'b0;
         rd_pend_q  <= 1'b0;
         bus_addr_q <= 8'h00;
      end
      else if (hready_in)
      begin
         wr_pend_q  <= hsel_in && htrans_in[1] && hwrite_in;
         rd_pend_q  <= hsel_in && htrans_in[1] && !hwrite_in;
         bus_addr_q <= haddr_in[7:0];
      end
   end

   assign hreadyout_out = 1'b1;
   assign hresp_out     = branch_logic_pkg::HRESP_OKAY;

   // read mux from registered address; unmapped offsets read zero
   always_comb
   begin
      hrdata_out = 32'h0;
      if (rd_pend_q)
      begin
         case (bus_addr_q)
            branch_logic_pkg::OFF_COND:   hrdata_out = condition_reg_q;
            branch_logic_pkg::OFF_RET_LO: hrdata_out = return_addr_reg_q[31:0];
            branch_logic_pkg::OFF_RET_HI: hrdata_out = return_addr_reg_q[63:32];
            branch_logic_pkg::OFF_CNT_LO: hrdata_out = loop_count_reg_q[31:0];
            branch_logic_pkg::OFF_CNT_HI: hrdata_out = loop_count_reg_q[63:32];
            branch_logic_pkg::OFF_CTRL:   hrdata_out = ctrl_q;
            branch_logic_pkg::OFF_STAT:
               hrdata_out = {30'h0, illegal_out, taken_out};
            default:                      hrdata_out = 32'h0;
         endcase
      end
   end

   // condition register; an instruction wins over a bus write that cycle
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
         condition_reg_q <= branch_logic_pkg::COND_RST;
      else if (do_crlog)
         condition_reg_q <= cond_next;
      else if (wr_pend_q && bus_addr_q == branch_logic_pkg::OFF_COND)
         condition_reg_q <= hwdata_in;
   end

   // return address: target was already taken from the old value above
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
         return_addr_reg_q <= branch_logic_pkg::RET_RST;
      else if (do_branch && link_in)
         return_addr_reg_q <= seq_addr;
      else if (wr_pend_q && bus_addr_q == branch_logic_pkg::OFF_RET_LO)
         return_addr_reg_q <= {return_addr_reg_q[63:32], hwdata_in};
      else if (wr_pend_q && bus_addr_q == branch_logic_pkg::OFF_RET_HI)
         return_addr_reg_q <= {hwdata_in, return_addr_reg_q[31:0]};
   end

   // loop count: decrement on every legal branch that asks for it
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
         loop_count_reg_q <= branch_logic_pkg::CNT_RST;
      else if (do_branch && eval_dec)
         loop_count_reg_q <= count_next;
      else if (wr_pend_q && bus_addr_q == branch_logic_pkg::OFF_CNT_LO)
         loop_count_reg_q <= {loop_count_reg_q[63:32], hwdata_in};
      else if (wr_pend_q && bus_addr_q == branch_logic_pkg::OFF_CNT_HI)
         loop_count_reg_q <= {hwdata_in, loop_count_reg_q[31:0]};
   end

   // control register: mode bit only
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
         ctrl_q <= branch_logic_pkg::CTRL_RST;
      else if (wr_pend_q && bus_addr_q == branch_logic_pkg::OFF_CTRL)
         ctrl_q <= {31'h0, hwdata_in[branch_logic_pkg::CTRL_MODE32_BIT]};
   end

   // result toward fetch, one cycle after issue
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         result_valid_out <= 1'b0;
         fetch_addr_out   <= 64'h0;
         taken_out        <= 1'b0;
         illegal_out      <= 1'b0;
      end
      else
      begin
         result_valid_out <= issue_valid_in;
         if (issue_valid_in)
         begin
            fetch_addr_out <= taken_d ? target_d : seq_addr;
            taken_out      <= taken_d;
            illegal_out    <= illegal_d;
         end
      end
   end

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   sequence s_issue(logic [3:0] op);
      issue_valid_in && op_in == op && !illegal_d;
   endsequence

   sequence s_result_taken;
      result_valid_out && taken_out && !illegal_out;
   endsequence

   a_rel_target : assert property (
      s_issue(branch_logic_pkg::OP_BR_UNCOND) ##0 !absolute_in |=>
      s_result_taken ##0
      (fetch_addr_out == $past(instr_addr_in) + $past(disp_in)))
      else $error("relative target not instruction address plus disp");

   a_abs_target : assert property (
      s_issue(branch_logic_pkg::OP_BR_UNCOND) ##0 absolute_in |=>
      s_result_taken ##0 (fetch_addr_out == $past(disp_in)))
      else $error("absolute target not the immediate");

   a_link_update : assert property (
      issue_valid_in && is_branch && !illegal_d && link_in |=>
      return_addr_reg_q == $past(instr_addr_in) + 64'h4)
      else $error("return address not the sequential address");

   a_ret_old_value : assert property (
      s_issue(branch_logic_pkg::OP_BR_RET) ##0 (taken_d && !mode32) |=>
      fetch_addr_out == ($past(return_addr_reg_q) & ~64'h3))
      else $error("return target not taken from old register");

   a_fall_through : assert property (
      issue_valid_in && is_branch && !taken_d |=>
      result_valid_out && !taken_out &&
      fetch_addr_out == $past(instr_addr_in) + 64'h4)
      else $error("not-taken branch did not supply next address");

   a_cnt_illegal : assert property (
      issue_valid_in && op_in == branch_logic_pkg::OP_BR_CNT &&
      !branch_option_field_in[2] && !wr_pend_q |=>
      illegal_out && !taken_out && $stable(loop_count_reg_q))
      else $error("count-register decrement form not refused");

   a_crlog_illegal : assert property (
      issue_valid_in && is_crlog && link_in && !wr_pend_q |=>
      illegal_out && $stable(condition_reg_q))
      else $error("condition op with link not refused");

   a_mode32_clear : assert property (
      issue_valid_in && mode32 && taken_d &&
      (op_in == branch_logic_pkg::OP_BR_RET ||
       op_in == branch_logic_pkg::OP_BR_CNT) |=>
      fetch_addr_out[63:32] == 32'h0 && fetch_addr_out[1:0] == 2'b00)
      else $error("indirect target not cleared in 32-bit mode");

   a_field_move : assert property (
      s_issue(branch_logic_pkg::OP_CR_MOVE) |=>
      !illegal_out &&
      (((condition_reg_q << {$past(dest_field_in), 2'b00}) &
        32'hf000_0000) ==
       (($past(condition_reg_q) << {$past(src_field_in), 2'b00}) &
        32'hf000_0000)) &&
      (((condition_reg_q ^ $past(condition_reg_q)) &
        ~(32'hf000_0000 >> {$past(dest_field_in), 2'b00})) == 32'h0))
      else $error("field move result wrong");

   a_cond_result : assert property (
      s_issue(branch_logic_pkg::OP_CR_XOR) |=>
      cond_bit(condition_reg_q, $past(dest_cond_bit_in)) ==
      ($past(cond_bit(condition_reg_q, src_bit_first_in)) ^
       $past(cond_bit(condition_reg_q, src_bit_second_in))))
      else $error("xor result not in destination bit");

endmodule : branch_and_cond_logic_unit

// [src/branch_cond_eval.sv]
// branch condition evaluator: option field, selected condition bit, count
// assumes operands are stable for the issue cycle; purely combinational
`timescale 1ns/1ps
module branch_cond_eval #(
   parameter int CNT_W = 64
) (
   // clock for the embedded checks only
   input  wire logic             sys_clk_in,
   input  wire logic             rst_in,
   // operands
   input  wire logic [4:0]       option_in,
   input  wire logic             cond_bit_in,
   input  wire logic [CNT_W-1:0] count_in,
   input  wire logic             mode32_in,
   input  wire logic             uncond_in,
   // results
   output logic                  taken_out,
   output logic                  dec_out,
   output logic [CNT_W-1:0]      count_next_out
);

   logic cnt_zero;
   logic cond_ok;
   logic cnt_ok;

   // decrement always spans the whole count; only the test narrows
   assign dec_out = !uncond_in && !option_in[branch_logic_pkg::OPT_NO_DEC];
   assign count_next_out = dec_out ? count_in - CNT_W'(1) : count_in;
   assign cnt_zero = mode32_in ? (count_next_out[31:0] == 32'h0)
                               : (count_next_out == '0);

   // hint bit is never looked at; ignored positions fall out of the terms
   assign cond_ok = option_in[branch_logic_pkg::OPT_NO_COND] ||
      (cond_bit_in == option_in[branch_logic_pkg::OPT_COND_TRUE]);
   assign cnt_ok = option_in[branch_logic_pkg::OPT_NO_DEC] ||
      (cnt_zero == option_in[branch_logic_pkg::OPT_ZERO_TEST]);
   assign taken_out = uncond_in || (cond_ok && cnt_ok);

   a_count_decrement : assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      dec_out |-> (count_next_out + CNT_W'(1)) == count_in)
      else $error("count not decremented by one");

   a_always_branch : assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      (option_in[4] && option_in[2]) |-> taken_out)
      else $error("branch-always encoding not taken");

endmodule : branch_cond_eval

// [src/branch_logic_pkg.sv]
// constants shared by the branch and condition-logic unit
// assumes a 64-bit core with a 32-bit register slave on AHB-Lite
package branch_logic_pkg;

   // widths
   localparam int ADDR_W  = 64;
   localparam int COND_W  = 32;
   localparam int SEL_W   = 5;
   localparam int FIELD_W = 3;
   localparam int OP_W    = 4;
   localparam int OPT_W   = 5;

   // decoded operation codes presented by instruction decode
   localparam logic [3:0] OP_IDLE       = 4'h0;
   localparam logic [3:0] OP_BR_UNCOND  = 4'h1;
   localparam logic [3:0] OP_BR_COND    = 4'h2;
   localparam logic [3:0] OP_BR_RET     = 4'h3;
   localparam logic [3:0] OP_BR_CNT     = 4'h4;
   localparam logic [3:0] OP_CR_ORC     = 4'h5;
   localparam logic [3:0] OP_CR_AND     = 4'h8;
   localparam logic [3:0] OP_CR_OR      = 4'h9;
   localparam logic [3:0] OP_CR_XOR     = 4'ha;
   localparam logic [3:0] OP_CR_NAND    = 4'hb;
   localparam logic [3:0] OP_CR_NOR     = 4'hc;
   localparam logic [3:0] OP_CR_EQV     = 4'hd;
   localparam logic [3:0] OP_CR_ANDC    = 4'he;
   localparam logic [3:0] OP_CR_MOVE    = 4'hf;

   // option field bit positions (msb is the first option bit)
   localparam int OPT_NO_COND    = 4;
   localparam int OPT_COND_TRUE  = 3;
   localparam int OPT_NO_DEC     = 2;
   localparam int OPT_ZERO_TEST  = 1;
   localparam int OPT_HINT       = 0;

   // register byte offsets
   localparam logic [7:0] OFF_COND   = 8'h00;
   localparam logic [7:0] OFF_RET_LO = 8'h04;
   localparam logic [7:0] OFF_RET_HI = 8'h08;
   localparam logic [7:0] OFF_CNT_LO = 8'h0c;
   localparam logic [7:0] OFF_CNT_HI = 8'h10;
   localparam logic [7:0] OFF_CTRL   = 8'h14;
   localparam logic [7:0] OFF_STAT   = 8'h18;

   // field positions
   localparam int CTRL_MODE32_BIT  = 0;
   localparam int STAT_TAKEN_BIT   = 0;
   localparam int STAT_ILLEGAL_BIT = 1;

   // reset values
   localparam logic [31:0] COND_RST = 32'h0000_0000;
   localparam logic [63:0] RET_RST  = 64'h0000_0000_0000_0000;
   localparam logic [63:0] CNT_RST  = 64'h0000_0000_0000_0000;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;

   // address arithmetic
   localparam logic [63:0] INSTR_BYTES  = 64'h0000_0000_0000_0004;
   localparam logic [63:0] ALIGN_MASK   = 64'hffff_ffff_ffff_fffc;
   localparam logic [63:0] LOW_HALF     = 64'h0000_0000_ffff_ffff;

   // bus encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic       HRESP_OKAY    = 1'b0;

endpackage : branch_logic_pkg

// [testbench/branch_and_cond_logic_unit_test.sv]
// self-checking bench for the branch and condition-logic unit
// assumes one clock, async reset, register access over AHB-Lite only
`timescale 1ns/1ps
module branch_and_cond_logic_unit_test;
   logic        clk, rst, hsel, hwrite, hrdy, hresp, iv, absl, lnk;
   logic        rv, tk, il, e_tk, e_il, m_m32;
   logic [31:0] haddr, hwdata, hrdata, m_cond, d;
   logic [31:0] lf = 32'h51aa;
   logic [1:0]  htrans;
   logic [3:0]  op;
   logic [4:0]  opt, sel, sa, sb, sd;
   logic [2:0]  sf, df;
   logic [63:0] ia, disp, fa, e_fa, m_ret, m_cnt;
   int          n_mismatch, tests_run, i, t;

   branch_and_cond_logic_unit branch_and_cond_logic_unit_i (
      .sys_clk_in(clk), .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
      .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata),
      .hreadyout_out(hrdy), .hresp_out(hresp), .issue_valid_in(iv),
      .op_in(op), .absolute_in(absl), .link_in(lnk),
      .branch_option_field_in(opt), .cond_selector_in(sel),
      .src_bit_first_in(sa), .src_bit_second_in(sb),
      .dest_cond_bit_in(sd), .src_field_in(sf), .dest_field_in(df),
      .instr_addr_in(ia), .disp_in(disp), .result_valid_out(rv),
      .fetch_addr_out(fa), .taken_out(tk), .illegal_out(il));

   // free-running 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // repeatable stimulus source
   function automatic logic [31:0] rnd();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return lf;
   endfunction : rnd

   task automatic chk_val(input logic [63:0] g, input logic [63:0] e);
      tests_run++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("BAD %0t value got %h want %h", $time, g, e);
      end
   endtask : chk_val

   task automatic chk_flag(input logic g, input logic e);
      tests_run++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("BAD %0t flag got %b want %b", $time, g, e);
      end
   endtask : chk_flag

   // one single-word transfer; waits on hready, data taken at its edge
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= branch_logic_pkg::HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      rd = hrdata;
      chk_flag(hresp, branch_logic_pkg::HRESP_OKAY);
      chk_flag(hrdy, 1'b1);
   endtask : bus

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk_val({32'h0, r}, {32'h0, e});
   endtask : rd_chk

   // reference: expected result and register side effects of one issue
   function automatic void predict(logic [3:0] o, logic ab, logic l,
      logic [4:0] p, logic [4:0] s, logic [4:0] x, logic [4:0] y,
      logic [4:0] z, logic [2:0] f, logic [2:0] g, logic [63:0] a,
      logic [63:0] dd);
      logic        bx, by, ok;
      logic [63:0] tg, n;
      n = m_cnt - 64'h1;
      ok = (p[4] || m_cond[31 - s] == p[3]) &&
           (p[2] || ((m_m32 ? n[31:0] == 0 : n == 0) == p[1]));
      e_il = (o inside {[4'h6:4'h7]}) || (o == 4'h4 && !p[2]) ||
             ((o[3] || o == 4'h5) && l);
      tg = ((o == 4'h3) ? m_ret : m_cnt) & branch_logic_pkg::ALIGN_MASK;
      if (m_m32) tg = tg & branch_logic_pkg::LOW_HALF;
      if (o < 4'h3) tg = ab ? dd : a + dd;
      e_tk = !e_il && (o == 4'h1 || (o inside {[4'h2:4'h4]} && ok));
      e_fa = e_tk ? tg : a + 64'h4;
      if (e_il) return;
      if ((o == 4'h2 || o == 4'h3) && !p[2]) m_cnt = n;
      if (l && !o[3]) m_ret = a + 64'h4;
      bx = m_cond[31 - x];
      by = m_cond[31 - y];
      case (o)
         4'h5: m_cond[31 - z] = bx | ~by;
         4'h8: m_cond[31 - z] = bx & by;
         4'h9: m_cond[31 - z] = bx | by;
         4'ha: m_cond[31 - z] = bx ^ by;
         4'hb: m_cond[31 - z] = ~(bx & by);
         4'hc: m_cond[31 - z] = ~(bx | by);
         4'hd: m_cond[31 - z] = ~(bx ^ by);
         4'he: m_cond[31 - z] = bx & ~by;
         4'hf: m_cond[31 - 4 * g -: 4] = m_cond[31 - 4 * f -: 4];
         default: ;
      endcase
   endfunction : predict

   // one issue with random operands, result checked the cycle after
   task automatic run(input logic [3:0] o, input logic l);
      logic [63:0] a, dd;
      logic [31:0] r;
      a = {rnd(), rnd()} & branch_logic_pkg::ALIGN_MASK;
      dd = {rnd(), rnd()} & branch_logic_pkg::ALIGN_MASK;
      r = rnd();
      predict(o, r[0], l, r[31:27], r[5:1], r[10:6], r[15:11], r[20:16],
              r[23:21], r[26:24], a, dd);
      @(posedge clk);
      iv <= 1'b1;
      op <= o;
      lnk <= l;
      absl <= r[0];
      opt <= r[31:27];
      sel <= r[5:1];
      sa <= r[10:6];
      sb <= r[15:11];
      sd <= r[20:16];
      sf <= r[23:21];
      df <= r[26:24];
      ia <= a;
      disp <= dd;
      @(posedge clk);
      iv <= 1'b0;
      #1;
      chk_flag(rv, 1'b1);
      chk_flag(tk, e_tk);
      chk_flag(il, e_il);
      chk_val(fa, e_fa);
   endtask : run

   // random registers; the count corner empties only its low half
   task automatic load(input logic corner);
      m_cond = rnd();
      m_ret = {rnd(), rnd()};
      m_cnt = corner ? 64'h0000_0001_0000_0001 : {rnd(), rnd()};
      bus(1'b1, 8'h00, m_cond, d);
      bus(1'b1, 8'h04, m_ret[31:0], d);
      bus(1'b1, 8'h08, m_ret[63:32], d);
      bus(1'b1, 8'h0c, m_cnt[31:0], d);
      bus(1'b1, 8'h10, m_cnt[63:32], d);
   endtask : load

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop

   // watchdog well beyond the expected run of about 40 us
   initial
   begin
      #200000;
      n_mismatch++;
      report_and_stop();
   end

   initial
   begin
      {rst, hsel, hwrite, iv, absl, lnk, m_m32} = 7'h40;
      {haddr, hwdata, htrans, op, opt, sel, sa, sb, sd, sf, df} = 'h0;
      {ia, disp} = 128'h0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      // reset values, including the unmapped word at 0x1c
      for (i = 0; i < 8; i++)
         rd_chk(8'(4 * i), 32'h0);
      $display("test reset done");
      for (t = 0; t < 2; t++)
      begin
         m_m32 = t[0];
         bus(1'b1, 8'h14, {31'h0, m_m32}, d);
         for (i = 0; i < 40; i++)
         begin
            load(i[0]);
            run(4'h1, i[1]);
            run(4'h2, i[2]);
            run(4'h3, i[3]);
            run(4'h4, i[1]);
            run({1'b1, i[2:0]}, i[3] & i[4]);
            run({1'b1, i[5:3]}, 1'b0);
            run(4'h5 + 4'(i % 3), i[0]);
            rd_chk(8'h00, m_cond);
            rd_chk(8'h04, m_ret[31:0]);
            rd_chk(8'h08, m_ret[63:32]);
            rd_chk(8'h0c, m_cnt[31:0]);
            rd_chk(8'h10, m_cnt[63:32]);
            rd_chk(8'h14, {31'h0, m_m32});
            rd_chk(8'h18, {30'h0, e_il, e_tk});
         end
         $display("test mode32=%0d done", t);
      end
      report_and_stop();
   end
endmodule : branch_and_cond_logic_unit_test
